// ==== hw/rsw_pkg.sv ====
package rsw_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned HOLD_DELAY_MS = 200;
  localparam int unsigned WATCHDOG_PERIOD_MS = 1600;
  localparam int unsigned HOLD_CYCLES = HOLD_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned WD_CYCLES = WATCHDOG_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_US = 100;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1000000);
  localparam int CNT_W = 32;
  localparam int DB_W = 16;

  // ==========================================================
  // output styles
  typedef enum logic [1:0] {
    RSW_PUSH_PULL = 2'b00,
    RSW_OD_EXT = 2'b01,
    RSW_OD_INT = 2'b10
  } rsw_drive_e;

  // ==========================================================
  // hold sequencer states
  typedef enum logic [1:0] {
    RSW_ST_ACTIVE = 2'b00,
    RSW_ST_HOLD = 2'b01,
    RSW_ST_RUN = 2'b10
  } rsw_state_e;

  typedef struct packed {
    logic supply_low;
    logic manual;
    logic watchdog;
  } rsw_src_s;
endpackage

// ==== hw/rsw_reset_supervisor_watchdog.sv ====
`timescale 1ns/10ps
`default_nettype none
module rsw_reset_supervisor_watchdog #(
  parameter int unsigned HOLD_COUNT = rsw_pkg::HOLD_CYCLES,
  parameter int unsigned WD_COUNT = rsw_pkg::WD_CYCLES,
  parameter int unsigned DEBOUNCE_COUNT = rsw_pkg::DEBOUNCE_CYCLES,
  parameter rsw_pkg::rsw_drive_e DRIVE = rsw_pkg::RSW_PUSH_PULL
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_supply_low,
  input wire logic i_manual_reset_n,
  input wire logic i_watchdog_kick_in,
  output logic o_reset_out_n,
  output logic o_reset_out_n_oe_n,
  output logic o_pullup_en,
  output logic o_reset_out,
  output rsw_pkg::rsw_src_s o_sources
);
  import rsw_pkg::*;

  // ==========================================================
  // synchronisers
  logic [2:0] sync1_reg;
  logic [2:0] sync1_next;
  logic [2:0] sync2_reg;
  logic [2:0] sync2_next;
  logic supply_low_s;
  logic mr_raw_s;
  logic kick_s;

  always_comb begin
    sync1_next = sync1_reg;
    sync2_next = sync2_reg;
    if (i_clk_en) begin
      sync1_next = {i_watchdog_kick_in, i_manual_reset_n, i_supply_low};
      sync2_next = sync1_reg;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  assign supply_low_s = sync2_reg[0];
  assign mr_raw_s = sync2_reg[1];
  assign kick_s = sync2_reg[2];

  // ==========================================================
  // manual reset debounce
  logic mr_n_reg;
  logic mr_n_next;
  logic [DB_W-1:0] db_cnt_reg;
  logic [DB_W-1:0] db_cnt_next;

  always_comb begin
    mr_n_next = mr_n_reg;
    db_cnt_next = db_cnt_reg;
    if (i_clk_en) begin
      if (mr_raw_s == mr_n_reg) begin
        db_cnt_next = '0;
      end else if (db_cnt_reg >= DB_W'(DEBOUNCE_COUNT - 1)) begin
        mr_n_next = mr_raw_s;
        db_cnt_next = '0;
      end else begin
        db_cnt_next = db_cnt_reg + DB_W'(1);
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mr_n_reg <= 1'b1;
      db_cnt_reg <= '0;
    end else begin
      mr_n_reg <= mr_n_next;
      db_cnt_reg <= db_cnt_next;
    end
  end

  // ==========================================================
  // kick edge detector
  logic kick_d_reg;
  logic kick_d_next;
  logic kick_edge;
  logic kick_fall;

  always_comb begin
    kick_d_next = kick_d_reg;
    kick_edge = 1'b0;
    kick_fall = 1'b0;
    if (i_clk_en) begin
      kick_d_next = kick_s;
      kick_edge = kick_s ^ kick_d_reg;
      kick_fall = kick_d_reg & ~kick_s;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      kick_d_reg <= 1'b1;
    end else begin
      kick_d_reg <= kick_d_next;
    end
  end

  // ==========================================================
  // watchdog
  logic wd_en_reg;
  logic wd_en_next;
  logic wd_fire_reg;
  logic wd_fire_next;
  logic [CNT_W-1:0] wd_cnt_reg;
  logic [CNT_W-1:0] wd_cnt_next;
  logic reset_active;

  always_comb begin
    wd_en_next = wd_en_reg;
    wd_fire_next = 1'b0;
    wd_cnt_next = wd_cnt_reg;
    if (i_clk_en) begin
      if (!wd_en_reg) begin
        wd_cnt_next = '0;
        if (kick_fall && !reset_active) begin
          wd_en_next = 1'b1;
        end
      end else if (kick_edge) begin
        wd_cnt_next = '0;
      end else if (wd_cnt_reg >= CNT_W'(WD_COUNT - 1)) begin
        wd_fire_next = 1'b1;
        wd_en_next = 1'b0;
        wd_cnt_next = '0;
      end else begin
        wd_cnt_next = wd_cnt_reg + CNT_W'(1);
      end
      if (reset_active && !wd_fire_next) begin
        wd_en_next = 1'b0;
        wd_cnt_next = '0;
      end
    end else begin
      wd_fire_next = wd_fire_reg;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wd_en_reg <= 1'b0;
      wd_fire_reg <= 1'b0;
      wd_cnt_reg <= '0;
    end else begin
      wd_en_reg <= wd_en_next;
      wd_fire_reg <= wd_fire_next;
      wd_cnt_reg <= wd_cnt_next;
    end
  end

  // ==========================================================
  // hold sequencer
  rsw_state_e state_reg;
  rsw_state_e state_next;
  logic [CNT_W-1:0] hold_cnt_reg;
  logic [CNT_W-1:0] hold_cnt_next;
  logic any_src;

  // power-up enters through the reset state of the sequencer
  assign any_src = supply_low_s | ~mr_n_reg | wd_fire_reg;
  assign reset_active = (state_reg != RSW_ST_RUN);

  always_comb begin
    state_next = state_reg;
    hold_cnt_next = hold_cnt_reg;
    if (i_clk_en) begin
      case (state_reg)
        RSW_ST_ACTIVE: begin
          hold_cnt_next = '0;
          if (!any_src) begin
            state_next = RSW_ST_HOLD;
          end
        end
        RSW_ST_HOLD: begin
          if (any_src) begin
            state_next = RSW_ST_ACTIVE;
            hold_cnt_next = '0;
          end else if (hold_cnt_reg >= CNT_W'(HOLD_COUNT - 1)) begin
            state_next = RSW_ST_RUN;
          end else begin
            hold_cnt_next = hold_cnt_reg + CNT_W'(1);
          end
        end
        RSW_ST_RUN: begin
          hold_cnt_next = '0;
          if (any_src) begin
            state_next = RSW_ST_ACTIVE;
          end
        end
        default: begin
          state_next = RSW_ST_ACTIVE;
          hold_cnt_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= RSW_ST_ACTIVE;
      hold_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      hold_cnt_reg <= hold_cnt_next;
    end
  end

  // ==========================================================
  // output drivers
  logic rst_n_next;
  logic oe_n_next;
  logic pu_next;
  logic rst_next;
  rsw_src_s src_next;

  always_comb begin
    rst_next = (state_next != RSW_ST_RUN);
    rst_n_next = ~rst_next;
    oe_n_next = 1'b0;
    pu_next = 1'b0;
    case (DRIVE)
      RSW_PUSH_PULL: begin
        oe_n_next = 1'b0;
      end
      RSW_OD_EXT: begin
        oe_n_next = ~rst_next;
      end
      RSW_OD_INT: begin
        oe_n_next = ~rst_next;
        pu_next = ~rst_next;
      end
      default: begin
        oe_n_next = 1'b0;
      end
    endcase
    if (!i_clk_en) begin
      rst_next = o_reset_out;
      rst_n_next = o_reset_out_n;
      oe_n_next = o_reset_out_n_oe_n;
      pu_next = o_pullup_en;
    end
    src_next = o_sources;
    if (i_clk_en) begin
      src_next.supply_low = supply_low_s;
      src_next.manual = ~mr_n_reg;
      src_next.watchdog = wd_fire_reg;
    end
  end

  // ==========================================================
  // output registers
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reset_out_n <= 1'b0;
      o_reset_out_n_oe_n <= 1'b0;
      o_pullup_en <= 1'b0;
      o_reset_out <= 1'b1;
      o_sources <= '0;
    end else begin
      o_reset_out_n <= rst_n_next;
      o_reset_out_n_oe_n <= oe_n_next;
      o_pullup_en <= pu_next;
      o_reset_out <= rst_next;
      o_sources <= src_next;
    end
  end
endmodule
`default_nettype wire

// ==== bench/rsw_checker_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
// ====
// checker
module rsw_checker
  import rsw_pkg::*;
#(
  parameter int unsigned HOLD_COUNT = HOLD_CYCLES,
  parameter int unsigned WD_COUNT = WD_CYCLES,
  parameter int unsigned DEBOUNCE_COUNT = DEBOUNCE_CYCLES,
  parameter rsw_drive_e DRIVE = RSW_PUSH_PULL
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_supply_low,
  input wire logic i_manual_reset_n,
  input wire logic i_watchdog_kick_in,
  input wire logic o_reset_out_n,
  input wire logic o_reset_out_n_oe_n,
  input wire logic o_pullup_en,
  input wire logic o_reset_out,
  input wire rsw_src_s o_sources
);
  int unsigned mlow, idle, kidle;
  logic kq, armed;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mlow <= 0;
      idle <= 0;
      kidle <= 0;
      kq <= 1'b1;
      armed <= 1'b0;
    end else begin
      mlow <= i_manual_reset_n ? 0 : mlow + 1;
      idle <= (i_supply_low || !i_manual_reset_n) ? 0 : idle + 1;
      kq <= i_watchdog_kick_in;
      kidle <= (kq != i_watchdog_kick_in) ? 0 : kidle + 1;
      armed <= o_reset_out ? 1'b0 : (armed || (kq && !i_watchdog_kick_in));
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  compl_outs_a: assert property (o_reset_out == !o_reset_out_n)
    else $error("reset outputs not complementary");
  supply_force_a: assert property (
    (i_supply_low && i_clk_en) [*6] |-> o_reset_out)
    else $error("supply low did not force reset");
  manual_force_a: assert property (
    mlow >= DEBOUNCE_COUNT + 8 |-> o_reset_out)
    else $error("manual reset did not force reset");
  hold_delay_a: assert property (
    $rose(o_reset_out_n) |-> idle >= HOLD_COUNT)
    else $error("reset released before hold delay");
  wd_period_a: assert property (
    $rose(o_sources.watchdog) |-> kidle >= WD_COUNT)
    else $error("watchdog fired early");
  wd_reset_a: assert property (
    o_sources.watchdog |-> ##[0:4] o_reset_out)
    else $error("watchdog timeout without reset");
  wd_armed_a: assert property (
    $rose(o_sources.watchdog) |-> armed)
    else $error("watchdog fired while disarmed");
  od_drive_a: assert property (
    o_reset_out_n_oe_n == (DRIVE != RSW_PUSH_PULL && o_reset_out_n))
    else $error("output enable wrong");
  pullup_on_a: assert property (
    o_pullup_en == (DRIVE == RSW_OD_INT && o_reset_out_n))
    else $error("pull-up enable wrong");
  cover property ($rose(o_sources.watchdog));
  cover property ($rose(o_sources.manual));
  cover property ($rose(o_reset_out_n));
endmodule
bind rsw_reset_supervisor_watchdog rsw_checker #(.HOLD_COUNT(HOLD_COUNT),
  .WD_COUNT(WD_COUNT), .DEBOUNCE_COUNT(DEBOUNCE_COUNT), .DRIVE(DRIVE))
  chk_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
  .i_supply_low(i_supply_low), .i_manual_reset_n(i_manual_reset_n),
  .i_watchdog_kick_in(i_watchdog_kick_in), .o_reset_out_n(o_reset_out_n),
  .o_reset_out_n_oe_n(o_reset_out_n_oe_n), .o_pullup_en(o_pullup_en),
  .o_reset_out(o_reset_out), .o_sources(o_sources));
`default_nettype wire

// ==== bench/rsw_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ====
// host controller kicking the watchdog
module rsw_host_model (
  input wire logic i_mclk,
  input wire logic i_reset_out_n,
  input wire logic i_run,
  output logic o_kick
);
  int cnt = 0;
  logic kick_q = 1'b1;
  assign o_kick = kick_q;
  always @(negedge i_mclk) begin
    if (!i_reset_out_n) begin
      kick_q <= 1'b1;
      cnt <= 0;
    end else if (i_run) begin
      cnt <= (cnt == 9) ? 0 : cnt + 1;
      if (cnt == 9) kick_q <= ~kick_q;
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// ====
// testbench
module tb;
  import rsw_pkg::*;
  logic mclk = 0, rst_n = 0, sup = 0, man_n = 1, run = 0, en = 1;
  logic kick, rn, oe_n, pu, ro;
  rsw_src_s src;
  int failures = 0, total_checks = 0, n;
  always #25 mclk = ~mclk;
  rsw_reset_supervisor_watchdog #(.HOLD_COUNT(20), .WD_COUNT(50),
    .DEBOUNCE_COUNT(4), .DRIVE(RSW_OD_INT)) DUT (.i_mclk(mclk),
    .i_reset_n(rst_n), .i_clk_en(en), .i_supply_low(sup),
    .i_manual_reset_n(man_n), .i_watchdog_kick_in(kick),
    .o_reset_out_n(rn), .o_reset_out_n_oe_n(oe_n), .o_pullup_en(pu),
    .o_reset_out(ro), .o_sources(src));
  rsw_host_model host (.i_mclk(mclk), .i_reset_out_n(rn), .i_run(run),
    .o_kick(kick));
  task end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wait_rn(input logic v, input int lim);
    n = 0;
    while (rn !== v && n < lim) begin
      @(negedge mclk);
      n++;
    end
    chk(rn, v);
    if (rn !== v) end_sim;
  endtask
  task t_power;
    chk({rn, oe_n, pu, ro}, 4'h1);
    wait_rn(1'b1, 60);
    chk(n >= 20, 1);
    chk({rn, oe_n, pu, ro}, 4'hE);
  endtask
  task t_supply;
    sup = 1'b1;
    repeat (8) @(negedge mclk);
    chk({rn, oe_n, pu, ro}, 4'h1);
    chk(src, 4'h4);
    sup = 1'b0;
    wait_rn(1'b1, 60);
    chk(n >= 20, 1);
  endtask
  task t_manual;
    man_n = 1'b0;
    repeat (2) @(negedge mclk);
    man_n = 1'b1;
    repeat (10) @(negedge mclk);
    chk({rn, oe_n, pu, ro}, 4'hE);
    man_n = 1'b0;
    repeat (40) @(negedge mclk);
    chk({rn, oe_n, pu, ro}, 4'h1);
    chk(src, 4'h2);
    man_n = 1'b1;
    wait_rn(1'b1, 60);
    chk(n >= 20, 1);
  endtask
  task t_watchdog;
    run = 1'b1;
    repeat (200) @(negedge mclk);
    chk({rn, oe_n, pu, ro}, 4'hE);
    run = 1'b0;
    wait_rn(1'b0, 80);
    chk(n >= 40, 1);
    wait_rn(1'b1, 60);
    repeat (150) @(negedge mclk);
    chk({rn, oe_n, pu, ro}, 4'hE);
  endtask
  task t_enable;
    en = 1'b0;
    sup = 1'b1;
    repeat (20) @(negedge mclk);
    chk({rn, oe_n, pu, ro}, 4'hE);
    chk(src, 4'h0);
    en = 1'b1;
    repeat (8) @(negedge mclk);
    chk({rn, oe_n, pu, ro}, 4'h1);
    sup = 1'b0;
    wait_rn(1'b1, 60);
    chk(n >= 20, 1);
  endtask
  initial begin
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    t_power;
    t_supply;
    t_manual;
    t_watchdog;
    t_enable;
    end_sim;
  end
endmodule
`default_nettype wire
